/* File: src/ccu_regs.vh */
/*
 * Register map, field positions, reset values and tick sources of the
 * dual timebase capture/compare unit.
 * Assumes byte addresses on an 8-bit Avalon-MM address, one word per register.
 */
`ifndef CCU_REGS_VH
`define CCU_REGS_VH

`define CCU_OFS_TB_CTRL    8'h00
`define CCU_OFS_TB0_COUNT  8'h04
`define CCU_OFS_TB0_RELOAD 8'h08
`define CCU_OFS_TB1_COUNT  8'h0c
`define CCU_OFS_TB1_RELOAD 8'h10
`define CCU_OFS_IRQ_STATUS 8'h14
`define CCU_OFS_IRQ_MASK   8'h18
`define CCU_OFS_PIN_STATE  8'h1c
`define CCU_OFS_VEC_CFG    8'h20
`define CCU_OFS_CH_VAL     2'b01
`define CCU_OFS_CH_CFG     2'b10

`define CCU_TB_RUN         0
`define CCU_TB_SRC_LO      1
`define CCU_TB_STAGGER     8
`define CCU_CF_EN          0
`define CCU_CF_CAP         1
`define CCU_CF_TBSEL       2
`define CCU_CF_MODE_LO     3
`define CCU_CF_ONCE        4
`define CCU_CF_SINGLE      5
`define CCU_CF_DBL         6
`define CCU_CF_RISE        7
`define CCU_CF_FALL        8
`define CCU_VC_SPC_LO      8

`define CCU_SRC_DIV1       3'h0
`define CCU_SRC_DIV8       3'h1
`define CCU_SRC_DIV64      3'h2
`define CCU_SRC_DIV512     3'h3
`define CCU_SRC_EXTOVF     3'h4
`define CCU_SRC_PIN        3'h5

`define CCU_RST_TB_CTRL    9'h000
`define CCU_RST_CH_CFG     9'h000
`define CCU_RST_VEC_CFG    10'h000
`define CCU_RST_WORD       16'h0000
`define CCU_CNT_MAX        16'hffff
`define CCU_NODE_BASE      16'h0040
`define CCU_TRAP_BASE      8'h10
`define CCU_STAGGER_LAST   3'h7
`define CCU_N_PINS         12
`define CCU_N_SHARED       14

`endif

/* File: src/ccu_timebase.v */
/*
 * One 16-bit reloadable timebase with prescaler and external tick sources.
 * Assumes ext_ovf and pin_edge are single-cycle pulses on mclk.
 */
`timescale 1ns/100ps
`include "ccu_regs.vh"

module ccu_timebase (
    input  wire        mclk,
    input  wire        rst,
    input  wire        ce,
    input  wire        run,
    input  wire [2:0]  src,
    input  wire        stagger,
    input  wire        slot,
    input  wire        ext_ovf,
    input  wire        pin_edge,
    input  wire        load,
    input  wire [15:0] load_val,
    input  wire [15:0] reload_val,
    output wire [15:0] count,
    output wire        tick,
    output wire        ovf
);
    reg  [8:0]  pre_reg;
    reg  [15:0] cnt_reg;
    reg         tick_reg;
    reg         ovf_reg;
    reg         pend_reg;
    reg         src_tick;
    wire        want;
    wire        go;

    always @* begin
        case (src)
            `CCU_SRC_DIV1:   src_tick = 1'b1;
            `CCU_SRC_DIV8:   src_tick = &pre_reg[2:0];
            `CCU_SRC_DIV64:  src_tick = &pre_reg[5:0];
            `CCU_SRC_DIV512: src_tick = &pre_reg;
            `CCU_SRC_EXTOVF: src_tick = ext_ovf;
            `CCU_SRC_PIN:    src_tick = pin_edge;
            default:         src_tick = 1'b0;
        endcase
    end

    // Staggered: a tick waits for the slot, so the grid is eight cycles
    assign want = run & (src_tick | pend_reg);
    assign go   = want & (~stagger | slot);

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            pre_reg  <= 9'h000;
            cnt_reg  <= `CCU_RST_WORD;
            tick_reg <= 1'b0;
            ovf_reg  <= 1'b0;
            pend_reg <= 1'b0;
        end else if (ce) begin
            pre_reg  <= pre_reg + 9'h001;
            pend_reg <= want & ~go;
            tick_reg <= go & ~load;
            ovf_reg  <= go & ~load & (cnt_reg == `CCU_CNT_MAX);
            if (load) begin
                cnt_reg <= load_val;
            end else if (go) begin
                if (cnt_reg == `CCU_CNT_MAX) begin
                    cnt_reg <= reload_val;
                end else begin
                    cnt_reg <= cnt_reg + 16'h0001;
                end
            end
        end
    end

    assign count = cnt_reg;
    assign tick  = tick_reg;
    assign ovf   = ovf_reg;
endmodule

/* File: src/ccu_top.v */
/*
 * Dual timebase capture/compare unit: 16 channels, two timebases,
 * twelve channel pins, sticky interrupts and vector/trap reporting.
 * Assumes an Avalon-MM master on mclk; pins and count input are asynchronous.
 */
// The Avalon-MM interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "ccu_regs.vh"

module ccu_top (
    input  wire        mclk,
    input  wire        rst,
    input  wire        ce,
    input  wire [7:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    input  wire [11:0] cc_pin_in,
    output wire [11:0] cc_pin_out,
    output wire [11:0] cc_pin_oe,
    input  wire        count_pin,
    input  wire        ext_timer_ovf,
    input  wire [13:0] shared_req,
    output wire        irq,
    output wire        node_valid,
    output wire [7:0]  node_segment,
    output wire [15:0] node_vector,
    output wire [7:0]  node_trap
);
    reg  [15:0] val_mem [0:15];
    reg  [8:0]  cfg_mem [0:15];
    reg  [8:0]  tb_ctrl_reg;
    reg  [15:0] rel0_reg;
    reg  [15:0] rel1_reg;
    reg  [15:0] status_reg;
    reg  [15:0] mask_reg;
    reg  [9:0]  vec_cfg_reg;
    reg  [15:0] armed_reg;
    reg  [11:0] pin_reg;
    reg  [11:0] pin_s1_reg;
    reg  [11:0] pin_s2_reg;
    reg  [11:0] pin_s3_reg;
    reg  [2:0]  cnt_s_reg;
    reg  [2:0]  phase_reg;
    reg         ack_reg;
    reg         irq_reg;
    reg         nvalid_reg;
    reg  [15:0] nvec_reg;
    reg  [7:0]  ntrap_reg;
    reg  [31:0] rd_next;
    reg  [3:0]  low_idx;
    reg         low_any;
    reg  [15:0] status_next;
    integer     k;
    integer     j;

    wire        acc;
    wire        wr_go;
    wire [3:0]  ch_idx;
    wire        ch_val_sel;
    wire        ch_cfg_sel;
    wire [15:0] tb0_cnt;
    wire [15:0] tb1_cnt;
    wire        tb0_tick;
    wire        tb1_tick;
    wire        tb0_ovf;
    wire        tb1_ovf;
    wire        slot;
    wire [15:0] match_w;
    wire [15:0] hit_w;
    wire [15:0] cap_w;
    wire [15:0] ovf_w;
    wire [15:0] cnt_w [0:15];
    wire [11:0] rise_w;
    wire [11:0] fall_w;
    wire [15:0] set_w;
    wire [15:0] pend_w;

    function [15:0] merge16;
        input [15:0] old;
        input [31:0] data;
        input [3:0]  be;
        begin
            merge16 = {be[1] ? data[15:8] : old[15:8], be[0] ? data[7:0] : old[7:0]};
        end
    endfunction

    function reg_hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            reg_hit = (addr == ofs);
        end
    endfunction

    // One wait state per access, frozen with the rest when ce is low
    assign acc             = (avs_read | avs_write) & ~ack_reg;
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign wr_go           = avs_write & ack_reg & ce;
    assign ch_idx          = avs_address[5:2];
    assign ch_val_sel      = (avs_address[7:6] == `CCU_OFS_CH_VAL) & (avs_address[1:0] == 2'b00);
    assign ch_cfg_sel      = (avs_address[7:6] == `CCU_OFS_CH_CFG) & (avs_address[1:0] == 2'b00);

    always @* begin
        rd_next = 32'h0000_0000;
        if (ch_val_sel) begin
            rd_next[15:0] = val_mem[ch_idx];
        end else if (ch_cfg_sel) begin
            rd_next[8:0] = cfg_mem[ch_idx];
        end else begin
            case (avs_address)
                `CCU_OFS_TB_CTRL:    rd_next[8:0]   = tb_ctrl_reg;
                `CCU_OFS_TB0_COUNT:  rd_next[15:0]  = tb0_cnt;
                `CCU_OFS_TB0_RELOAD: rd_next[15:0]  = rel0_reg;
                `CCU_OFS_TB1_COUNT:  rd_next[15:0]  = tb1_cnt;
                `CCU_OFS_TB1_RELOAD: rd_next[15:0]  = rel1_reg;
                `CCU_OFS_IRQ_STATUS: rd_next[15:0]  = status_reg;
                `CCU_OFS_IRQ_MASK:   rd_next[15:0]  = mask_reg;
                `CCU_OFS_PIN_STATE:  rd_next[23:0]  = {pin_s2_reg, pin_reg};
                `CCU_OFS_VEC_CFG:    rd_next[9:0]   = vec_cfg_reg;
                default:             rd_next        = 32'h0000_0000;
            endcase
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            ack_reg      <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else if (ce) begin
            ack_reg <= acc;
            if (acc & avs_read) begin
                avs_readdata <= rd_next;
            end
        end
    end

    // Asynchronous pins: two flops, the third only feeds edge detection
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            pin_s1_reg <= 12'h000;
            pin_s2_reg <= 12'h000;
            pin_s3_reg <= 12'h000;
            cnt_s_reg  <= 3'h0;
            phase_reg  <= 3'h0;
        end else if (ce) begin
            pin_s1_reg <= cc_pin_in;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            cnt_s_reg  <= {cnt_s_reg[1:0], count_pin};
            phase_reg  <= phase_reg + 3'h1;
        end
    end

    assign rise_w = pin_s2_reg & ~pin_s3_reg;
    assign fall_w = ~pin_s2_reg & pin_s3_reg;
    assign slot   = (phase_reg == `CCU_STAGGER_LAST);

    ccu_timebase u_primary_timebase (
        .mclk       (mclk),
        .rst        (rst),
        .ce         (ce),
        .run        (tb_ctrl_reg[`CCU_TB_RUN]),
        .src        (tb_ctrl_reg[`CCU_TB_SRC_LO +: 3]),
        .stagger    (tb_ctrl_reg[`CCU_TB_STAGGER]),
        .slot       (slot),
        .ext_ovf    (ext_timer_ovf),
        .pin_edge   (cnt_s_reg[1] & ~cnt_s_reg[2]),
        .load       (wr_go & reg_hit(avs_address, `CCU_OFS_TB0_COUNT)),
        .load_val   (merge16(tb0_cnt, avs_writedata, avs_byteenable)),
        .reload_val (rel0_reg),
        .count      (tb0_cnt),
        .tick       (tb0_tick),
        .ovf        (tb0_ovf)
    );

    ccu_timebase u_secondary_timebase (
        .mclk       (mclk),
        .rst        (rst),
        .ce         (ce),
        .run        (tb_ctrl_reg[`CCU_TB_RUN + 4]),
        .src        (tb_ctrl_reg[`CCU_TB_SRC_LO + 4 +: 3]),
        .stagger    (tb_ctrl_reg[`CCU_TB_STAGGER]),
        .slot       (slot),
        .ext_ovf    (ext_timer_ovf),
        .pin_edge   (1'b0),
        .load       (wr_go & reg_hit(avs_address, `CCU_OFS_TB1_COUNT)),
        .load_val   (merge16(tb1_cnt, avs_writedata, avs_byteenable)),
        .reload_val (rel1_reg),
        .count      (tb1_cnt),
        .tick       (tb1_tick),
        .ovf        (tb1_ovf)
    );

    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : g_ch
            wire sel = cfg_mem[g][`CCU_CF_TBSEL];
            wire cmp = cfg_mem[g][`CCU_CF_EN] & ~cfg_mem[g][`CCU_CF_CAP];
            assign cnt_w[g]   = sel ? tb1_cnt : tb0_cnt;
            assign ovf_w[g]   = sel ? tb1_ovf : tb0_ovf;
            // Count and tick change on one edge, so equality is seen once
            assign match_w[g] = (sel ? tb1_tick : tb0_tick) & (cnt_w[g] == val_mem[g]);
            // Modes 2 and 3 fire once, then wait for the overflow
            assign hit_w[g]   = cmp & match_w[g] &
                                (~cfg_mem[g][`CCU_CF_ONCE] | armed_reg[g]);
            if (g < `CCU_N_PINS) begin : g_pin
                assign cap_w[g] = cfg_mem[g][`CCU_CF_EN] & cfg_mem[g][`CCU_CF_CAP] &
                                  ((cfg_mem[g][`CCU_CF_RISE] & rise_w[g]) |
                                   (cfg_mem[g][`CCU_CF_FALL] & fall_w[g]));
                // Pin stays driven after a single event so its level holds
                assign cc_pin_oe[g] = ~cfg_mem[g][`CCU_CF_CAP] &
                                      (cfg_mem[g][`CCU_CF_MODE_LO] |
                                       (g < 8 && cfg_mem[g][`CCU_CF_DBL]));
            end else begin : g_nopin
                assign cap_w[g] = 1'b0;
            end
        end
    endgenerate

    // Shared nodes: routed requests land on the same status bits
    assign set_w = hit_w | cap_w | {2'b00, shared_req};

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (k = 0; k < 16; k = k + 1) begin
                val_mem[k] <= `CCU_RST_WORD;
                cfg_mem[k] <= `CCU_RST_CH_CFG;
            end
            armed_reg <= 16'hffff;
            pin_reg   <= 12'h000;
        end else if (ce) begin
            for (k = 0; k < 16; k = k + 1) begin
                if (cap_w[k]) begin
                    val_mem[k] <= cnt_w[k];
                end
                if (ovf_w[k]) begin
                    armed_reg[k] <= 1'b1;
                end else if (hit_w[k]) begin
                    armed_reg[k] <= 1'b0;
                end
                // Single event: the channel switches itself off
                if ((hit_w[k] | cap_w[k]) & cfg_mem[k][`CCU_CF_SINGLE]) begin
                    cfg_mem[k][`CCU_CF_EN] <= 1'b0;
                end
                if (k < `CCU_N_PINS) begin
                    if (cfg_mem[k][`CCU_CF_CAP]) begin
                        pin_reg[k] <= 1'b0;
                    end else if (cfg_mem[k][`CCU_CF_ONCE] & cfg_mem[k][`CCU_CF_MODE_LO]) begin
                        // Overflow reset acts even when disabled: single pulse
                        if (hit_w[k]) begin
                            pin_reg[k] <= 1'b1;
                        end else if (ovf_w[k]) begin
                            pin_reg[k] <= 1'b0;
                        end
                    end else if (k < 8 && cfg_mem[k][`CCU_CF_DBL]) begin
                        if (match_w[k] & cfg_mem[k][`CCU_CF_EN] ^
                            hit_w[k + 8]) begin
                            pin_reg[k] <= ~pin_reg[k];
                        end
                    end else if (cfg_mem[k][`CCU_CF_MODE_LO] & hit_w[k]) begin
                        pin_reg[k] <= ~pin_reg[k];
                    end
                end
            end
            if (wr_go & ch_val_sel) begin
                val_mem[ch_idx] <= merge16(val_mem[ch_idx], avs_writedata, avs_byteenable);
            end
            if (wr_go & ch_cfg_sel) begin
                if (avs_byteenable[0]) begin
                    cfg_mem[ch_idx][7:0] <= avs_writedata[7:0];
                end
                if (avs_byteenable[1]) begin
                    cfg_mem[ch_idx][8] <= avs_writedata[8];
                end
            end
        end
    end

    // Hardware set wins over a write-one clear in the same cycle
    always @* begin
        status_next = status_reg;
        if (wr_go & reg_hit(avs_address, `CCU_OFS_IRQ_STATUS)) begin
            status_next = status_reg & ~merge16(16'h0000, avs_writedata, avs_byteenable);
        end
        status_next = status_next | set_w;
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            tb_ctrl_reg <= `CCU_RST_TB_CTRL;
            rel0_reg    <= `CCU_RST_WORD;
            rel1_reg    <= `CCU_RST_WORD;
            mask_reg    <= `CCU_RST_WORD;
            status_reg  <= `CCU_RST_WORD;
            vec_cfg_reg <= `CCU_RST_VEC_CFG;
        end else if (ce) begin
            status_reg <= status_next;
            if (wr_go) begin
                case (avs_address)
                    `CCU_OFS_TB_CTRL: begin
                        if (avs_byteenable[0]) begin
                            tb_ctrl_reg[7:0] <= avs_writedata[7:0];
                        end
                        if (avs_byteenable[1]) begin
                            tb_ctrl_reg[8] <= avs_writedata[8];
                        end
                    end
                    `CCU_OFS_TB0_RELOAD: rel0_reg <= merge16(rel0_reg, avs_writedata,
                                                             avs_byteenable);
                    `CCU_OFS_TB1_RELOAD: rel1_reg <= merge16(rel1_reg, avs_writedata,
                                                             avs_byteenable);
                    `CCU_OFS_IRQ_MASK: mask_reg <= merge16(mask_reg, avs_writedata,
                                                           avs_byteenable);
                    `CCU_OFS_VEC_CFG: begin
                        if (avs_byteenable[0]) begin
                            vec_cfg_reg[7:0] <= avs_writedata[7:0];
                        end
                        if (avs_byteenable[1]) begin
                            vec_cfg_reg[9:8] <= avs_writedata[9:8];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Lowest channel wins the node report
    assign pend_w = status_reg & mask_reg;

    always @* begin
        low_idx = 4'h0;
        low_any = 1'b0;
        for (j = 15; j >= 0; j = j - 1) begin
            if (pend_w[j]) begin
                low_idx = j[3:0];
                low_any = 1'b1;
            end
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_reg    <= 1'b0;
            nvalid_reg <= 1'b0;
            nvec_reg   <= `CCU_NODE_BASE;
            ntrap_reg  <= `CCU_TRAP_BASE;
        end else if (ce) begin
            irq_reg    <= |pend_w;
            nvalid_reg <= low_any;
            // Spacing 4 bytes by default, doubled per spacing step
            nvec_reg   <= `CCU_NODE_BASE +
                          (({12'h000, low_idx} << 2) << vec_cfg_reg[`CCU_VC_SPC_LO +: 2]);
            ntrap_reg  <= `CCU_TRAP_BASE + {4'h0, low_idx};
        end
    end

    assign irq          = irq_reg;
    assign node_valid   = nvalid_reg;
    assign node_segment = vec_cfg_reg[7:0];
    assign node_vector  = nvec_reg;
    assign node_trap    = ntrap_reg;
    assign cc_pin_out   = pin_reg;
endmodule

/* File: bench/ccu_chk_assertions.sv */
/* Port checker for ccu_top: bus handshake, vectors, irq timing.
   Assumes bind onto ccu_top; mask and vector writes use lanes 0 and 1. */
`timescale 1ns/100ps
`include "ccu_regs.vh"
module ccu_chk (
    input wire        mclk,
    input wire        rst,
    input wire        ce,
    input wire [7:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    input wire [13:0] shared_req,
    input wire        irq,
    input wire        node_valid,
    input wire [7:0]  node_segment,
    input wire [15:0] node_vector,
    input wire [7:0]  node_trap
);
    reg  [15:0] msk_reg;
    reg  [7:0]  seg_reg;
    reg  [1:0]  spc_reg;
    wire        wr_ok = avs_write && !avs_waitrequest && ce;
    // Shadow copies, since the checker cannot see the registers
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            msk_reg <= 16'h0000;
            seg_reg <= 8'h00;
            spc_reg <= 2'h0;
        end else if (wr_ok) begin
            if (avs_address == `CCU_OFS_IRQ_MASK)
                msk_reg <= avs_writedata[15:0];
            if (avs_address == `CCU_OFS_VEC_CFG) begin
                seg_reg <= avs_writedata[7:0];
                spc_reg <= avs_writedata[9:8];
            end
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_take; (avs_read || avs_write) && avs_waitrequest && ce; endsequence
    sequence s_ack; (avs_read || avs_write) && !avs_waitrequest; endsequence
    property p_one_wait; s_take ##1 ce |-> !avs_waitrequest; endproperty
    property p_rewait; s_ack ##1 (avs_read || avs_write) |-> avs_waitrequest; endproperty
    property p_idle; !(avs_read || avs_write) |-> !avs_waitrequest; endproperty
    property p_rd_hold; !(avs_read && avs_waitrequest) |=> $stable(avs_readdata); endproperty
    property p_unmapped;
        avs_read && !avs_waitrequest && avs_address > 8'h20 && avs_address < 8'h40
            |-> avs_readdata == 32'h0;
    endproperty
    property p_trap; node_trap >= 8'h10 && node_trap <= 8'h1f; endproperty
    property p_vec;
        node_valid && $stable(spc_reg)
            |-> node_vector == 16'h0040 + ({8'h00, node_trap - 8'h10} << 2 << spc_reg);
    endproperty
    property p_seg; node_segment == seg_reg; endproperty
    property p_irq; |(shared_req & msk_reg[13:0]) |-> ##2 irq; endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait not one cycle");
    a_rewait: assert property (p_rewait) else $error("no wait on next request");
    a_idle: assert property (p_idle) else $error("wait without request");
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_trap: assert property (p_trap) else $error("trap out of range");
    a_vec: assert property (p_vec) else $error("vector mismatch");
    a_seg: assert property (p_seg) else $error("segment mismatch");
    a_irq: assert property (p_irq) else $error("irq late");
endmodule
bind ccu_top ccu_chk u_chk (.mclk(mclk), .rst(rst), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .shared_req(shared_req), .irq(irq), .node_valid(node_valid),
    .node_segment(node_segment), .node_vector(node_vector), .node_trap(node_trap));

/* File: bench/ccu_pins.sv */
/* Far-side model: channel pin wires, count input, external overflow.
   Assumes ext_lvl is set by the bench for pins the unit does not drive. */
`timescale 1ns/100ps
module ccu_pins (
    input  wire        mclk,
    input  wire        rst,
    input  wire [11:0] pin_out,
    input  wire [11:0] pin_oe,
    input  wire [11:0] ext_lvl,
    output wire [11:0] pin_in,
    output reg         count_pin,
    output reg         ext_ovf
);
    reg [2:0] div_reg;
    // Driven pins read back the unit's own level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            div_reg <= 3'h0;
            count_pin <= 1'b0;
            ext_ovf <= 1'b0;
        end else begin
            div_reg <= div_reg + 3'h1;
            ext_ovf <= (div_reg == 3'h7);
            count_pin <= div_reg[1];
        end
    end
endmodule

/* File: bench/test_dual_timebase_capture_compare.sv */
/* Self-checking bench for ccu_top, one task per scenario.
   Assumes ccu_top as declared and the pin model beside it. */
`timescale 1ns/100ps
`include "ccu_regs.vh"
module test_dual_timebase_capture_compare;
    reg         mclk, rst, ce, avs_read, avs_write;
    reg  [7:0]  avs_address;
    reg  [31:0] avs_writedata, rd;
    reg  [3:0]  avs_byteenable;
    reg  [11:0] ext_lvl;
    reg  [13:0] shared_req;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest, irq, node_valid, count_pin, ext_timer_ovf;
    wire [11:0] cc_pin_in, cc_pin_out, cc_pin_oe;
    wire [7:0]  node_segment, node_trap;
    wire [15:0] node_vector;
    integer     errors, total_checks, cyc = 0;
    always #25 mclk = ~mclk;
    ccu_top u_dut (.mclk(mclk), .rst(rst), .ce(ce), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cc_pin_in(cc_pin_in), .cc_pin_out(cc_pin_out),
        .cc_pin_oe(cc_pin_oe), .count_pin(count_pin), .ext_timer_ovf(ext_timer_ovf),
        .shared_req(shared_req), .irq(irq), .node_valid(node_valid),
        .node_segment(node_segment), .node_vector(node_vector), .node_trap(node_trap));
    ccu_pins u_pins (.mclk(mclk), .rst(rst), .pin_out(cc_pin_out), .pin_oe(cc_pin_oe),
        .ext_lvl(ext_lvl), .pin_in(cc_pin_in), .count_pin(count_pin),
        .ext_ovf(ext_timer_ovf));
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            total_checks = total_checks + 1;
            if (g !== e) begin
                errors = errors + 1;
                $display("[ERR] %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    // Request held until waitrequest is seen low at a rising edge
    task bus(input wr, input [7:0] a, input [31:0] d);
        begin
            @(posedge mclk);
            avs_address <= a;
            avs_writedata <= d;
            avs_write <= wr;
            avs_read <= !wr;
            @(posedge mclk);
            while (avs_waitrequest !== 1'b0)
                @(posedge mclk);
            rd = avs_readdata;
            avs_write <= 1'b0;
            avs_read <= 1'b0;
        end
    endtask
    task wait_pin(input integer b, input v);
        integer n;
        begin
            n = 0;
            while (cc_pin_out[b] !== v && n < 40) begin
                @(negedge mclk);
                n = n + 1;
            end
            chk("pin", {31'h0, v}, {31'h0, cc_pin_out[b]});
        end
    endtask
    task t_reset;
        begin
            bus(0, `CCU_OFS_TB_CTRL, 0);
            chk("tb_ctrl", 32'h0, rd);
            bus(0, 8'h80, 0);
            chk("ch0_cfg", 32'h0, rd);
            bus(0, 8'h30, 0);
            chk("unmapped", 32'h0, rd);
            chk("vector", 32'h40, {16'h0, node_vector});
            chk("trap", 32'h10, {24'h0, node_trap});
            $display("reset test done");
        end
    endtask
    task t_capture;
        begin
            bus(1, `CCU_OFS_TB0_COUNT, 32'h1234);
            bus(1, 8'h8c, 32'h083);
            ext_lvl[3] <= 1'b1;
            repeat (8) @(posedge mclk);
            bus(0, 8'h4c, 0);
            chk("capture", 32'h1234, rd);
            bus(0, `CCU_OFS_IRQ_STATUS, 0);
            chk("cap_stat", 32'h8, rd);
            bus(1, `CCU_OFS_IRQ_STATUS, 32'h8);
            bus(0, `CCU_OFS_IRQ_STATUS, 0);
            chk("w1c", 32'h0, rd);
            $display("capture test done");
        end
    endtask
    task t_cmp0;
        integer n;
        begin
            bus(1, `CCU_OFS_IRQ_MASK, 32'h1);
            bus(1, `CCU_OFS_TB0_RELOAD, 32'hfff0);
            bus(1, `CCU_OFS_TB0_COUNT, 32'hfff0);
            bus(1, 8'h40, 32'hfff4);
            bus(1, 8'h80, 32'h001);
            bus(1, `CCU_OFS_TB_CTRL, 32'h001);
            n = 0;
            while (irq !== 1'b1 && n < 40) begin
                @(negedge mclk);
                n = n + 1;
            end
            chk("irq", 32'h1, {31'h0, irq});
            chk("trap0", 32'h10, {24'h0, node_trap});
            chk("pin0", 32'h0, {31'h0, cc_pin_out[0]});
            bus(1, `CCU_OFS_IRQ_STATUS, 32'h1);
            repeat (20) @(posedge mclk);
            bus(0, `CCU_OFS_IRQ_STATUS, 0);
            chk("again", 32'h1, rd & 32'h1);
            $display("mode 0 test done");
        end
    endtask
    task t_pins;
        begin
            bus(1, 8'h44, 32'hfff8);
            bus(1, 8'h84, 32'h009);
            bus(1, 8'h48, 32'hfffa);
            bus(1, 8'h88, 32'h019);
            wait_pin(1, 1'b1);
            wait_pin(1, 1'b0);
            wait_pin(2, 1'b1);
            wait_pin(2, 1'b0);
            chk("oe", 32'h3, {30'h0, cc_pin_oe[2:1]});
            $display("pin test done");
        end
    endtask
    task t_vec;
        begin
            bus(1, `CCU_OFS_TB_CTRL, 0);
            bus(1, `CCU_OFS_IRQ_STATUS, 32'hffff);
            bus(1, `CCU_OFS_VEC_CFG, 32'h0105);
            bus(1, `CCU_OFS_IRQ_MASK, 32'h2000);
            @(posedge mclk);
            shared_req <= 14'h2000;
            @(posedge mclk);
            shared_req <= 14'h0;
            repeat (3) @(posedge mclk);
            chk("vec13", 32'ha8, {16'h0, node_vector});
            chk("trap13", 32'h1d, {24'h0, node_trap});
            chk("seg", 32'h5, {24'h0, node_segment});
            chk("irq13", 32'h1, {31'h0, irq});
            chk("nv", 32'h1, {31'h0, node_valid});
            $display("vector test done");
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", total_checks, errors);
            if (errors == 0 && total_checks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            errors = errors + 1;
            complete_run;
        end
    end
    initial begin
        mclk = 0; rst = 1; ce = 1; avs_read = 0; avs_write = 0; avs_address = 0;
        avs_writedata = 0; avs_byteenable = 4'hf; ext_lvl = 0; shared_req = 0;
        errors = 0; total_checks = 0;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        t_reset;
        t_capture;
        t_cmp0;
        t_pins;
        t_vec;
        complete_run;
    end
endmodule
